// ===== hdl/flr_pkg.sv
// Package for the flash/torch LED control register bank.
// Assumes an I2C-compatible front end delivers decoded byte writes and reads.
package flr_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_TORCH_RAMP = 8'h06;
    localparam logic [7:0] ADDR_CONFIG = 8'h07;
    localparam logic [7:0] ADDR_FLASH_FEAT = 8'h08;
    localparam logic [7:0] ADDR_CURRENT = 8'h09;
    localparam logic [7:0] ADDR_ENABLE = 8'h0A;
    localparam logic [7:0] ADDR_FLAGS = 8'h0B;
    // ----------------------------------------------------------------
    // Reset values and writable masks
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_TORCH_RAMP = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h78;
    localparam logic [7:0] RST_FLASH_FEAT = 8'h12;
    localparam logic [7:0] RST_CURRENT = 8'h0F;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    localparam logic [7:0] MASK_TORCH_RAMP = 8'h3F;
    localparam logic [7:0] MASK_CURRENT = 8'h7F;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CFG_STROBE_LEVEL = 7;
    localparam int CFG_STROBE_POL = 6;
    localparam int CFG_TORCH_POL = 5;
    localparam int CFG_RF_POL = 4;
    localparam int CFG_RF_TO_TORCH = 3;
    localparam int CFG_INPUT_VOLTAGE_FLASH_MONITOR_EN = 2;
    localparam int CFG_THERM_MONITOR = 1;
    localparam int CFG_IND_EXTERNAL = 0;
    localparam int EN_THERM = 7;
    localparam int EN_RF = 6;
    localparam int EN_STROBE = 5;
    localparam int EN_TORCH = 4;
    localparam int EN_PRECHARGE = 3;
    localparam int EN_PASS_ONLY = 2;
    localparam int FLAG_RF_EVENT = 7;
    // ----------------------------------------------------------------
    // Modes and bundles
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'h0,
        MODE_INDICATOR = 2'h1,
        MODE_TORCH = 2'h2,
        MODE_FLASH = 2'h3
    } flr_mode_t;

    typedef struct packed {
        logic strobe;
        logic torch;
        logic rf_pulse;
    } flr_pins_t;

    typedef struct packed {
        logic led_on;
        logic at_torch_level;
        logic flash_active;
        logic torch_active;
        logic pass_only;
        logic precharge;
        logic input_voltage_flash_monitor_en;
        logic therm_en;
        logic therm_monitor;
        logic ind_external;
        logic [1:0] peak_limit;
        logic [2:0] flash_ramp;
        logic [2:0] flash_timeout;
        logic [2:0] torch_up;
        logic [2:0] torch_down;
        logic [2:0] torch_code;
        logic [3:0] flash_code;
    } flr_ctrl_t;

    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int FLASH_STEP_MS = 100;
    localparam int FLASH_STEP_CYC = CLK_HZ / 1000 * FLASH_STEP_MS;
endpackage

// ===== hdl/flr_regs.sv
// Register bank and pin-facing control for the LED flash/torch driver.
// Assumes byte writes/reads arrive from an I2C-compatible slave on clk_in;
// strobe, torch and RF-pulse pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module flr_regs (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire flr_pkg::flr_pins_t pins_in,
    input wire logic [6:0] fault_in,
    output logic [7:0] rdata_out,
    output flr_pkg::flr_ctrl_t ctrl_out
);
    import flr_pkg::*;

    logic [7:0] torch_ramp_times_ff;
    logic [7:0] pin_and_response_config_ff;
    logic [7:0] flash_timing_and_limit_ff;
    logic [7:0] led_current_levels_ff;
    logic [7:0] function_enables_and_mode_ff;
    logic [7:0] flags_ff;
    logic [7:0] rdata_ff;
    flr_ctrl_t ctrl_ff;
    flr_pins_t sync1_ff;
    flr_pins_t sync2_ff;
    logic strobe_prev_ff;
    logic flash_run_ff;
    logic [31:0] flash_cnt_ff;
    logic pass_latch_ff;
    logic mode_lock;
    logic strobe_act;
    logic torch_act;
    logic rf_act;
    logic strobe_rise;
    logic [1:0] mode;
    logic in_flash;
    logic in_torch;
    logic [31:0] timeout_cycles;

    function automatic logic pin_active(input logic raw, input logic pol_high);
        pin_active = pol_high ? raw : ~raw;
    endfunction

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= pins_in;
            sync2_ff <= sync1_ff;
        end
    end

    assign strobe_act = pin_active(sync2_ff.strobe, pin_and_response_config_ff[CFG_STROBE_POL]);
    assign torch_act = pin_active(sync2_ff.torch, pin_and_response_config_ff[CFG_TORCH_POL]);
    assign rf_act = pin_active(sync2_ff.rf_pulse, pin_and_response_config_ff[CFG_RF_POL]) &
                    function_enables_and_mode_ff[EN_RF];
    assign strobe_rise = strobe_act & ~strobe_prev_ff;
    assign mode = function_enables_and_mode_ff[1:0];
    assign mode_lock = flags_ff[FLAG_RF_EVENT];
    assign timeout_cycles = (32'(flash_timing_and_limit_ff[2:0]) + 32'h1) * 32'(FLASH_STEP_CYC);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            torch_ramp_times_ff <= RST_TORCH_RAMP;
            pin_and_response_config_ff <= RST_CONFIG;
            flash_timing_and_limit_ff <= RST_FLASH_FEAT;
            led_current_levels_ff <= RST_CURRENT;
            function_enables_and_mode_ff <= RST_ENABLE;
        end else if (wr_en_in) begin
            case (addr_in)
                ADDR_TORCH_RAMP: torch_ramp_times_ff <= wdata_in & MASK_TORCH_RAMP;
                ADDR_CONFIG: pin_and_response_config_ff <= wdata_in;
                ADDR_FLASH_FEAT: flash_timing_and_limit_ff <= wdata_in;
                ADDR_CURRENT: led_current_levels_ff <= wdata_in & MASK_CURRENT;
                ADDR_ENABLE: begin
                    // Mode bits frozen while the RF event flag stands
                    function_enables_and_mode_ff[7:2] <= wdata_in[7:2];
                    if (!mode_lock) begin
                        function_enables_and_mode_ff[1:0] <= wdata_in[1:0];
                    end
                end
                default: ;
            endcase
        end else if (flash_run_ff && mode == MODE_FLASH && !pin_and_response_config_ff[CFG_STROBE_LEVEL] &&
                     flash_cnt_ff >= timeout_cycles) begin
            // Time-out returns the part to standby
            function_enables_and_mode_ff[1:0] <= MODE_STANDBY;
        end
    end

    // ----------------------------------------------------------------
    // Flags: hardware set beats read clear
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= (rd_en_in && addr_in == ADDR_FLAGS) ? 8'h00 : flags_ff;
            if (rf_act && (mode == MODE_TORCH || mode == MODE_INDICATOR) &&
                !pin_and_response_config_ff[CFG_RF_TO_TORCH]) begin
                flags_ff[FLAG_RF_EVENT] <= 1'b1;
            end
            if (flash_run_ff && !pin_and_response_config_ff[CFG_STROBE_LEVEL] && flash_cnt_ff >= timeout_cycles) begin
                flags_ff[0] <= 1'b1;
            end
            for (int i = 0; i < 7; i++) begin
                if (fault_in[i]) begin
                    flags_ff[i] <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Flash sequencing
    // ----------------------------------------------------------------
    // Pin enable clear means the bus write alone starts the flash
    assign in_flash = (mode == MODE_FLASH) && (!function_enables_and_mode_ff[EN_STROBE] ||
                      (pin_and_response_config_ff[CFG_STROBE_LEVEL] ? strobe_act : (flash_run_ff | strobe_rise)));
    assign in_torch = (mode == MODE_TORCH) && (!function_enables_and_mode_ff[EN_TORCH] || torch_act);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            strobe_prev_ff <= 1'b0;
            flash_run_ff <= 1'b0;
            flash_cnt_ff <= '0;
        end else begin
            strobe_prev_ff <= strobe_act;
            flash_run_ff <= in_flash;
            flash_cnt_ff <= in_flash ? flash_cnt_ff + 32'h1 : 32'h0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pass_latch_ff <= 1'b0;
        end else if (mode == MODE_STANDBY) begin
            pass_latch_ff <= 1'b0;
        end else if (function_enables_and_mode_ff[EN_PASS_ONLY]) begin
            pass_latch_ff <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Control outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_ff <= '0;
        end else begin
            // RF off response kills only a flash; torch level otherwise
            ctrl_ff.led_on <= (in_flash && !(rf_act && !pin_and_response_config_ff[CFG_RF_TO_TORCH])) ||
                              in_torch || mode == MODE_INDICATOR;
            ctrl_ff.at_torch_level <= in_flash && rf_act && pin_and_response_config_ff[CFG_RF_TO_TORCH];
            ctrl_ff.flash_active <= in_flash;
            ctrl_ff.torch_active <= in_torch;
            ctrl_ff.pass_only <= pass_latch_ff | function_enables_and_mode_ff[EN_PASS_ONLY];
            ctrl_ff.precharge <= function_enables_and_mode_ff[EN_PRECHARGE];
            ctrl_ff.input_voltage_flash_monitor_en <= pin_and_response_config_ff[CFG_INPUT_VOLTAGE_FLASH_MONITOR_EN];
            ctrl_ff.therm_en <= function_enables_and_mode_ff[EN_THERM];
            ctrl_ff.therm_monitor <= pin_and_response_config_ff[CFG_THERM_MONITOR];
            ctrl_ff.ind_external <= pin_and_response_config_ff[CFG_IND_EXTERNAL];
            ctrl_ff.peak_limit <= flash_timing_and_limit_ff[7:6];
            ctrl_ff.flash_ramp <= flash_timing_and_limit_ff[5:3];
            ctrl_ff.flash_timeout <= flash_timing_and_limit_ff[2:0];
            ctrl_ff.torch_up <= torch_ramp_times_ff[5:3];
            ctrl_ff.torch_down <= torch_ramp_times_ff[2:0];
            ctrl_ff.torch_code <= led_current_levels_ff[6:4];
            ctrl_ff.flash_code <= led_current_levels_ff[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rdata_ff <= '0;
        end else if (rd_en_in) begin
            case (addr_in)
                ADDR_TORCH_RAMP: rdata_ff <= torch_ramp_times_ff;
                ADDR_CONFIG: rdata_ff <= pin_and_response_config_ff;
                ADDR_FLASH_FEAT: rdata_ff <= flash_timing_and_limit_ff;
                ADDR_CURRENT: rdata_ff <= led_current_levels_ff;
                ADDR_ENABLE: rdata_ff <= function_enables_and_mode_ff;
                ADDR_FLAGS: rdata_ff <= flags_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end
    end

    assign rdata_out = rdata_ff;
    assign ctrl_out = ctrl_ff;
endmodule
`default_nettype wire

// ===== tb/flr_regs_asserts.sv
// Checker for the LED control register bank: field timing at ctrl_out and read data.
// Assumes it is bound to flr_regs and watches only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module flr_regs_asserts
    import flr_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire flr_pkg::flr_pins_t pins_in,
    input wire logic [6:0] fault_in,
    input wire logic [7:0] rdata_out,
    input wire flr_pkg::flr_ctrl_t ctrl_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Register takes the write edge, ctrl_out follows one edge later
    sequence s_wr(a); wr_en_in && addr_in == a; endsequence
    a_torch_ramp: assert property (s_wr(ADDR_TORCH_RAMP) |-> ##2
        {2'h0, ctrl_out.torch_up, ctrl_out.torch_down} == ($past(wdata_in, 2) & 8'h3F)) else $error("ramp codes");
    a_config_fields: assert property (s_wr(ADDR_CONFIG) |-> ##2
        {ctrl_out.input_voltage_flash_monitor_en, ctrl_out.therm_monitor, ctrl_out.ind_external} == $past(wdata_in[2:0], 2))
        else $error("config fields");
    a_flash_fields: assert property (s_wr(ADDR_FLASH_FEAT) |-> ##2
        {ctrl_out.peak_limit, ctrl_out.flash_ramp, ctrl_out.flash_timeout} == $past(wdata_in, 2))
        else $error("flash fields");
    a_current_codes: assert property (s_wr(ADDR_CURRENT) |-> ##2
        {ctrl_out.torch_code, ctrl_out.flash_code} == $past(wdata_in[6:0], 2)) else $error("current codes");
    a_enable_fields: assert property (s_wr(ADDR_ENABLE) |-> ##2
        {ctrl_out.therm_en, ctrl_out.precharge} == {$past(wdata_in[7], 2), $past(wdata_in[3], 2)})
        else $error("enable fields");
    a_reserved_zero: assert property ((rd_en_in && addr_in == ADDR_TORCH_RAMP) |=>
        rdata_out[7:6] == 2'h0) else $error("reserved bits read nonzero");
    a_flash_start: assert property ((wr_en_in && addr_in == ADDR_ENABLE && wdata_in[1:0] == 2'h3
        && !wdata_in[EN_STROBE]) |-> ##2 ctrl_out.flash_active) else $error("flash did not start on write");
    a_pass_held: assert property ((ctrl_out.pass_only && ctrl_out.torch_active && wr_en_in
        && addr_in == ADDR_ENABLE && wdata_in[1:0] == 2'h2) |-> ##2 ctrl_out.pass_only)
        else $error("pass-only released while lit");
endmodule
bind flr_regs flr_regs_asserts i_flr_regs_asserts (.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .pins_in(pins_in), .fault_in(fault_in),
    .rdata_out(rdata_out), .ctrl_out(ctrl_out));
`default_nettype wire

// ===== tb/flr_host.sv
// Host model: issues single-byte register writes and reads on the decoded access port.
// Assumes read data is valid 2 ns after the edge that samples the read.
`timescale 1ns/100ps
`default_nettype none
module flr_host (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic wr_en_out,
    output logic rd_en_out,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out
);
    initial {wr_en_out, rd_en_out, addr_out, wdata_out} = 18'h0FF00;
    // Released address and data are inverted so stale values never look valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_in);
        #2;
        wr_en_out = w;
        rd_en_out = !w;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #2;
        {wr_en_out, rd_en_out, addr_out, wdata_out} = {2'b00, ~a, ~d};
        q = rdata_in;
    endtask
endmodule
`default_nettype wire

// ===== tb/flr_regs_tb.sv
// Testbench for the LED control register bank: register access, modes and pin events.
// Assumes the host model drives the access port; pins and faults are driven here.
`timescale 1ns/100ps
`default_nettype none
module flr_regs_tb;
    import flr_pkg::*;
    localparam int B_LED = 30, B_TLV = 29, B_FLASH = 28, B_TORCH = 27;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic wr_en, rd_en;
    logic [7:0] addr, wdata, rdata, rv;
    flr_pins_t pins = '0;
    logic [6:0] fault = 7'h00;
    flr_ctrl_t ctrl;
    int num_errors = 0;
    int samples_checked = 0;
    always #25 clk_in = ~clk_in;
    flr_host i_flr_host (.clk_in(clk_in), .rdata_in(rdata), .wr_en_out(wr_en), .rd_en_out(rd_en),
        .addr_out(addr), .wdata_out(wdata));
    flr_regs i_flr_regs (.clk_in(clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
        .addr_in(addr), .wdata_in(wdata), .pins_in(pins), .fault_in(fault), .rdata_out(rdata),
        .ctrl_out(ctrl));
    task automatic results();
        if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        i_flr_host.xfer(1'b0, a, 8'h00, rv);
        check(rv, exp);
    endtask
    // Bounded wait on one ctrl_out bit; running out ends the run
    task automatic wait_ctrl(input int b, input logic v);
        int n = 0;
        while (ctrl[b] !== v && n < 40) begin
            @(posedge clk_in);
            #2;
            n++;
        end
        check({7'h00, ctrl[b]}, {7'h00, v});
        // Only a real time-out ends the run early
        if (n == 40 && ctrl[b] !== v) results();
    endtask
    initial begin
        logic [7:0] rst_tab [5] = '{8'h00, 8'h78, 8'h12, 8'h0F, 8'h00};
        logic [7:0] wr_tab [5] = '{8'hFF, 8'hF7, 8'hAD, 8'hFF, 8'hB1};
        logic [7:0] msk_tab [5] = '{8'h3F, 8'hFF, 8'hFF, 8'h7F, 8'hFF};
        repeat (16) @(posedge clk_in);
        #2 rst_n_in = 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(8'(ADDR_TORCH_RAMP + i), rst_tab[i]);
            i_flr_host.xfer(1'b1, 8'(ADDR_TORCH_RAMP + i), wr_tab[i], rv);
            rd(8'(ADDR_TORCH_RAMP + i), wr_tab[i] & msk_tab[i]);
        end
        rd(8'h0C, 8'h00);
        i_flr_host.xfer(1'b1, ADDR_ENABLE, 8'h06, rv);
        wait_ctrl(B_TORCH, 1'b1);
        // Off response in torch: flag set, mode bits locked
        i_flr_host.xfer(1'b1, ADDR_ENABLE, 8'h42, rv);
        pins.rf_pulse = 1'b1;
        repeat (4) @(posedge clk_in);
        #2 pins.rf_pulse = 1'b0;
        i_flr_host.xfer(1'b1, ADDR_ENABLE, 8'h40, rv);
        // Standby request refused: mode bits still torch, upper bits taken
        rd(ADDR_ENABLE, 8'h42);
        i_flr_host.xfer(1'b1, ADDR_ENABLE, 8'h02, rv);
        check({7'h00, ctrl.torch_active}, 8'h01);
        rd(ADDR_FLAGS, 8'h80);
        i_flr_host.xfer(1'b1, ADDR_ENABLE, 8'h00, rv);
        wait_ctrl(B_TORCH, 1'b0);
        // Level strobe flash, RF event drops to torch level
        i_flr_host.xfer(1'b1, ADDR_CONFIG, 8'hF8, rv);
        i_flr_host.xfer(1'b1, ADDR_ENABLE, 8'h63, rv);
        pins.strobe = 1'b1;
        wait_ctrl(B_FLASH, 1'b1);
        pins.rf_pulse = 1'b1;
        wait_ctrl(B_TLV, 1'b1);
        pins.rf_pulse = 1'b0;
        pins.strobe = 1'b0;
        wait_ctrl(B_FLASH, 1'b0);
        i_flr_host.xfer(1'b0, ADDR_FLAGS, 8'h00, rv);
        i_flr_host.xfer(1'b1, ADDR_ENABLE, 8'h00, rv);
        // Off response during flash shuts the output down
        i_flr_host.xfer(1'b1, ADDR_CONFIG, 8'hF0, rv);
        i_flr_host.xfer(1'b1, ADDR_ENABLE, 8'h43, rv);
        wait_ctrl(B_FLASH, 1'b1);
        pins.rf_pulse = 1'b1;
        wait_ctrl(B_LED, 1'b0);
        pins.rf_pulse = 1'b0;
        i_flr_host.xfer(1'b1, ADDR_ENABLE, 8'h00, rv);
        i_flr_host.xfer(1'b0, ADDR_FLAGS, 8'h00, rv);
        fault = 7'h05;
        @(posedge clk_in);
        #2 fault = 7'h00;
        rd(ADDR_FLAGS, 8'h05);
        rd(ADDR_FLAGS, 8'h00);
        results();
    end
endmodule
`default_nettype wire
